//--- hw/prs_phase.sv
// reset-sequence phase tracker driven by supply good
`timescale 1ns/1ns
module prs_phase (
  input  wire logic             core_clk,     // core clock
  input  wire logic             resetn,       // async reset, active low
  input  wire logic             supply_good,  // supply-good input
  output prs_pkg::prs_phase_t   phase_q,      // current phase
  output logic [4:0]            xdiv_q,       // synth x divisor
  output logic [5:0]            zdiv_q        // synth z divisor
);
  prs_pkg::prs_phase_t phase_d;
  logic [4:0] xdiv_d;
  logic [5:0] zdiv_d;
  always_comb begin
    phase_d = phase_q;
    xdiv_d  = xdiv_q;
    zdiv_d  = zdiv_q;
    case (phase_q)
      prs_pkg::PH_SETTLE: begin
        if (supply_good) begin
          phase_d = prs_pkg::PH_NOMINAL;
          xdiv_d  = prs_pkg::XDIV_START;
          zdiv_d  = prs_pkg::ZDIV_START;
        end
      end
      prs_pkg::PH_NOMINAL: phase_d = prs_pkg::PH_NOMINAL;
      default: phase_d = prs_pkg::PH_SETTLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= prs_pkg::PH_SETTLE;
      xdiv_q  <= 5'h00;
      zdiv_q  <= 6'h00;
    end else begin
      phase_q <= phase_d;
      xdiv_q  <= xdiv_d;
      zdiv_q  <= zdiv_d;
    end
  end
endmodule

//--- hw/prs_pkg.sv
// package: register indices, field layouts and reset values for the reset-state register bank
package prs_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_FW_BASE   = 6'h00;
  localparam logic [5:0] OFF_ICTL      = 6'h01;
  localparam logic [5:0] OFF_PROCESS_CONTEXT      = 6'h02;
  localparam logic [5:0] OFF_TAG_A     = 6'h03;
  localparam logic [5:0] OFF_TAG_B     = 6'h04;
  localparam logic [5:0] OFF_ENT_A     = 6'h05;
  localparam logic [5:0] OFF_ENT_B     = 6'h06;
  localparam logic [5:0] OFF_ASN_A     = 6'h07;
  localparam logic [5:0] OFF_ASN_B     = 6'h08;
  localparam logic [5:0] OFF_MCTL      = 6'h09;
  localparam logic [5:0] OFF_DCCTL     = 6'h0A;
  localparam logic [5:0] OFF_INTERRUPT_ENABLE_CURRENT_MODE    = 6'h0B;
  localparam logic [5:0] OFF_HWINT_CLR = 6'h0C;
  localparam logic [5:0] OFF_ISTAT     = 6'h0D;
  localparam logic [5:0] OFF_PERF_COUNTER_CONTROL  = 6'h0E;
  localparam logic [5:0] OFF_CC        = 6'h0F;
  localparam logic [5:0] OFF_CYCLE_COUNTER_CONTROL    = 6'h10;
  localparam logic [5:0] OFF_VIRTUAL_ADDRESS_CONTROL    = 6'h11;
  localparam logic [5:0] OFF_DCSTAT    = 6'h12;
  localparam logic [5:0] OFF_ALTMODE   = 6'h13;
  localparam logic [5:0] OFF_CDATA     = 6'h14;
  localparam logic [5:0] OFF_ITB_FLUSH = 6'h15;
  localparam logic [5:0] OFF_DTB_FLUSH = 6'h16;
  localparam logic [5:0] OFF_STATUS    = 6'h17;
  localparam int unsigned NUM_REGS = 24;
  localparam int unsigned ICTL_ICACHE_SET_ENABLE_LSB = 0;
  localparam logic [1:0]  ICTL_ICACHE_SET_ENABLE_RST = 2'h3;
  localparam int unsigned PROCESS_CONTEXT_FPE_BIT   = 2;
  localparam logic [31:0] ZERO_RST       = 32'h0000_0000;
  localparam logic [31:0] DCCTL_RST      = 32'h0000_0003;
  localparam logic [31:0] UNDEF_RST      = 32'h0000_0000;
  localparam int unsigned ST_ITB_FLUSHED = 0;
  localparam int unsigned ST_DTB_FLUSHED = 1;
  localparam int unsigned ST_CDATA_READ  = 2;
  localparam int unsigned ST_SUPPLY_GOOD = 3;
  localparam int unsigned ST_TEST_RST    = 4;
  localparam int unsigned ST_PHASE_LSB   = 8;
  localparam logic [4:0] XDIV_START = 5'h10;
  localparam logic [5:0] ZDIV_START = 6'h20;
  typedef enum logic [1:0] {PH_SETTLE = 2'b00, PH_NOMINAL = 2'b01} prs_phase_t;
endpackage

//--- hw/prs_reg.sv
// one 32-bit register with a constant power-up value
`timescale 1ns/1ns
module prs_reg #(
  parameter logic [31:0] RST = 32'h0000_0000
) (
  input  wire logic        core_clk, // core clock
  input  wire logic        resetn,   // async reset, active low
  input  wire logic        wr_en,    // write strobe
  input  wire logic [31:0] wr_data,  // write data
  output logic      [31:0] val_q     // stored value
);
  logic [31:0] val_d;
  always_comb begin
    val_d = val_q;
    if (wr_en) begin
      val_d = wr_data;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      val_q <= RST;
    end else begin
      val_q <= val_d;
    end
  end
endmodule

//--- hw/prs_top.sv
// processor register bank with power-up reset values, on an Avalon-MM slave
`timescale 1ns/1ns
module prs_top (
  input  wire logic        core_clk,              // 125 MHz core clock
  input  wire logic        resetn,                // power-up reset, async, active low
  input  wire logic [5:0]  avs_address,           // word index
  input  wire logic        avs_read,              // read request
  input  wire logic        avs_write,             // write request
  input  wire logic [31:0] avs_writedata,         // write data
  input  wire logic [3:0]  avs_byteenable,        // byte lanes
  output logic      [31:0] avs_readdata,          // read data
  output logic             avs_waitrequest,       // stall
  output logic      [1:0]  avs_response,          // 00 okay, 10 slave error
  input  wire logic        supply_good,           // supply-good input
  input  wire logic        test_reset_n,          // boundary-scan test reset, active low
  output logic             test_logic_in_reset,   // test logic held in reset
  output logic      [4:0]  synth_xdiv,            // clock synth x divisor
  output logic      [5:0]  synth_zdiv,            // clock synth z divisor
  output logic      [1:0]  icache_set_enable,     // live icache enable field
  output logic             float_enable_bit       // live float enable
);
  localparam int unsigned N = prs_pkg::NUM_REGS;

  // first access cycle stalls, second answers: keeps readdata registered
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  resp_q;
  logic [1:0]  resp_d;
  logic [31:0] merged;
  logic [N-1:0] wr_sel;
  logic [31:0] regs [N];
  logic [31:0] status_d;
  logic [31:0] status_q;
  logic        busy;
  prs_pkg::prs_phase_t phase;

  assign busy = avs_read | avs_write;

  always_comb begin
    ack_d = busy & ~ack_q;
  end

  assign avs_waitrequest = busy & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;

  // byte enables merge into the current value
  always_comb begin
    merged = (avs_address < 6'(N)) ? regs[avs_address[4:0]] : 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable[b]) begin
        merged[8*b +: 8] = avs_writedata[8*b +: 8];
      end
    end
  end

  always_comb begin
    wr_sel = '0;
    if (avs_write && ack_q && (avs_address < 6'(prs_pkg::OFF_STATUS))) begin
      wr_sel[avs_address[4:0]] = 1'b1;
    end
  end

  // power-up values: undefined registers take an arbitrary zero
  function automatic logic [31:0] rst_of(input int unsigned i);
    logic [31:0] v;
    v = prs_pkg::UNDEF_RST;
    case (i)
      int'(prs_pkg::OFF_FW_BASE): v = prs_pkg::ZERO_RST;
      int'(prs_pkg::OFF_ICTL): begin
        v = prs_pkg::ZERO_RST;
        v[prs_pkg::ICTL_ICACHE_SET_ENABLE_LSB +: 2] = prs_pkg::ICTL_ICACHE_SET_ENABLE_RST;
      end
      int'(prs_pkg::OFF_PROCESS_CONTEXT): begin
        v = prs_pkg::UNDEF_RST;
        v[prs_pkg::PROCESS_CONTEXT_FPE_BIT] = 1'b1;
      end
      int'(prs_pkg::OFF_TAG_A), int'(prs_pkg::OFF_TAG_B),
      int'(prs_pkg::OFF_ENT_A), int'(prs_pkg::OFF_ENT_B): v = prs_pkg::ZERO_RST;
      int'(prs_pkg::OFF_ASN_A), int'(prs_pkg::OFF_ASN_B),
      int'(prs_pkg::OFF_MCTL): v = prs_pkg::ZERO_RST;
      int'(prs_pkg::OFF_DCCTL): v = prs_pkg::DCCTL_RST;
      default: v = prs_pkg::UNDEF_RST;
    endcase
    return v;
  endfunction

  for (genvar g = 0; g < N - 1; g++) begin : g_reg
    prs_reg #(
      .RST (rst_of(g))
    ) u_reg (
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr_en    (wr_sel[g]),
      .wr_data  (merged),
      .val_q    (regs[g])
    );
  end
  assign regs[N-1] = status_q;

  prs_phase u_phase (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .supply_good (supply_good),
    .phase_q     (phase),
    .xdiv_q      (synth_xdiv),
    .zdiv_q      (synth_zdiv)
  );

  // firmware bring-up progress, sticky until power-up reset; supply-good, test-reset and phase bits follow their inputs each cycle
  always_comb begin
    status_d = status_q;
    if (wr_sel[prs_pkg::OFF_ITB_FLUSH[4:0]]) begin
      status_d[prs_pkg::ST_ITB_FLUSHED] = 1'b1;
    end
    if (wr_sel[prs_pkg::OFF_DTB_FLUSH[4:0]]) begin
      status_d[prs_pkg::ST_DTB_FLUSHED] = 1'b1;
    end
    if (avs_read && ack_q && avs_address == prs_pkg::OFF_CDATA) begin
      status_d[prs_pkg::ST_CDATA_READ] = 1'b1;
    end
    status_d[prs_pkg::ST_SUPPLY_GOOD] = supply_good;
    status_d[prs_pkg::ST_TEST_RST]    = ~test_reset_n;
    status_d[prs_pkg::ST_PHASE_LSB +: 2] = phase;
  end

  always_comb begin
    rdata_d = rdata_q;
    resp_d  = resp_q;
    if (busy && !ack_q) begin
      resp_d = (avs_address < 6'(N)) ? 2'h0 : 2'h2;
      if (avs_read) begin
        rdata_d = (avs_address < 6'(N)) ? regs[avs_address[4:0]] : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      resp_q   <= 2'h0;
      status_q <= 32'h0000_0000;
    end else begin
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      resp_q   <= resp_d;
      status_q <= status_d;
    end
  end

  // test reset only holds the scan logic; functional state sees it only through status bit ST_TEST_RST
  assign test_logic_in_reset = ~test_reset_n;
  assign icache_set_enable   = regs[prs_pkg::OFF_ICTL[4:0]][prs_pkg::ICTL_ICACHE_SET_ENABLE_LSB +: 2];
  assign float_enable_bit    = regs[prs_pkg::OFF_PROCESS_CONTEXT[4:0]][prs_pkg::PROCESS_CONTEXT_FPE_BIT];
endmodule

//--- verif/prs_pwr_model.sv
// supply and test-reset sequencer standing in for the board
`timescale 1ns/1ns
module prs_pwr_model (
  input  wire logic core_clk,    // core clock
  input  wire logic resetn,      // power-up reset
  input  wire logic rel_req,     // bench asks to free test reset
  output logic      supply_good, // supply settled
  output logic      test_reset_n // test reset, active low
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q        <= 4'h0;
      supply_good  <= 1'b0;
      test_reset_n <= 1'b0;
    end else begin
      cnt_q        <= (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
      supply_good  <= cnt_q >= 4'h8; // supply settles a while after reset
      test_reset_n <= rel_req && supply_good;
    end
  end
endmodule

//--- verif/prs_top_chk.sv
// checker: power-up values, divisors, test reset
`timescale 1ns/1ns
module prs_top_chk (
  input wire logic        core_clk,            // core clock
  input wire logic        resetn,              // power-up reset, active low
  input wire logic [5:0]  avs_address,         // word index
  input wire logic        avs_read,            // read request
  input wire logic        avs_write,           // write request
  input wire logic [31:0] avs_readdata,        // read data
  input wire logic        avs_waitrequest,     // stall
  input wire logic [1:0]  avs_response,        // response code
  input wire logic        supply_good,         // supply settled
  input wire logic        test_reset_n,        // test reset, active low
  input wire logic        test_logic_in_reset, // test logic held
  input wire logic [4:0]  synth_xdiv,          // synth x divisor
  input wire logic [5:0]  synth_zdiv,          // synth z divisor
  input wire logic [1:0]  icache_set_enable,   // icache enable field
  input wire logic        float_enable_bit     // float enable
);
  logic [23:0] wr_q; // defaults stand only until written
  logic        rq;
  assign rq = avs_read && avs_waitrequest;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) wr_q <= '0;
    else if (avs_write && !avs_waitrequest && avs_address < 6'h18) wr_q[avs_address[4:0]] <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_BAD_IDX: assert property ((rq || avs_write) && avs_waitrequest && avs_address > 6'h17 |=> avs_response == 2'h2)
    else $error("no error response");
  AST_ICTL: assert property (rq && avs_address == 6'h01 && !wr_q[1] |=> avs_readdata == 32'h3)
    else $error("control reset value");
  AST_ICEN: assert property (!wr_q[1] |-> icache_set_enable == 2'h3)
    else $error("icache enable");
  AST_FPE: assert property (!wr_q[2] |-> float_enable_bit)
    else $error("float enable");
  AST_ZERO: assert property (rq && avs_address inside {6'h00, [6'h03:6'h09]}
    && !wr_q[avs_address[4:0]] |=> avs_readdata == 32'h0) else $error("cleared register");
  AST_DCCTL: assert property (rq && avs_address == 6'h0A && !wr_q[10]
    |=> avs_readdata == prs_pkg::DCCTL_RST) else $error("cache control value");
  AST_TRST: assert property (test_logic_in_reset == !test_reset_n)
    else $error("test reset view");
  AST_TRST_RUN: assert property (test_logic_in_reset && rq |=> !avs_waitrequest)
    else $error("bus stalled while test reset held");
  AST_LOCK: assert property (supply_good |=> synth_xdiv == 5'h10 && synth_zdiv == 6'h20)
    else $error("startup divisors");
  AST_IDLE: assert property (!supply_good && synth_xdiv == 5'h0 |=> $stable(synth_xdiv) && synth_zdiv == 6'h0)
    else $error("early divisors");
  cover property (rq && avs_address > 6'h17);
  cover property (avs_write && !avs_waitrequest && avs_address == 6'h16);
  cover property ($rose(test_reset_n));
endmodule
bind prs_top prs_top_chk i_prs_top_chk (
  .core_clk            (core_clk),
  .resetn              (resetn),
  .avs_address         (avs_address),
  .avs_read            (avs_read),
  .avs_write           (avs_write),
  .avs_readdata        (avs_readdata),
  .avs_waitrequest     (avs_waitrequest),
  .avs_response        (avs_response),
  .supply_good         (supply_good),
  .test_reset_n        (test_reset_n),
  .test_logic_in_reset (test_logic_in_reset),
  .synth_xdiv          (synth_xdiv),
  .synth_zdiv          (synth_zdiv),
  .icache_set_enable   (icache_set_enable),
  .float_enable_bit    (float_enable_bit)
);

//--- verif/tb_top.sv
// bench: power-up values, bring-up writes, refusals, second reset
`timescale 1ns/1ns
module tb_top;
  logic        core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, rel_req = 0;
  logic [5:0]  avs_address = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = '0, rnd = 32'h5FD4, v, avs_readdata;
  logic        avs_waitrequest, supply_good, test_reset_n, test_logic_in_reset, float_enable_bit;
  logic [1:0]  avs_response, icache_set_enable;
  logic [4:0]  synth_xdiv;
  logic [5:0]  synth_zdiv;
  logic [65:0] n, notes[$];
  int          fail_count = 0, checks_done = 0, cycles = 0;
  prs_top i_prs_top (
    .core_clk            (core_clk),
    .resetn              (resetn),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .avs_response        (avs_response),
    .supply_good         (supply_good),
    .test_reset_n        (test_reset_n),
    .test_logic_in_reset (test_logic_in_reset),
    .synth_xdiv          (synth_xdiv),
    .synth_zdiv          (synth_zdiv),
    .icache_set_enable   (icache_set_enable),
    .float_enable_bit    (float_enable_bit)
  );
  prs_pwr_model i_prs_pwr_model (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .rel_req      (rel_req),
    .supply_good  (supply_good),
    .test_reset_n (test_reset_n)
  );
  always #4 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // a read files its masked expectation before it starts
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    if (!w) notes.push_back({m, a > 6'h17 ? 2'h2 : 2'h0, e});
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      tally_and_finish();
    end else if (avs_read && avs_waitrequest === 1'b0) begin
      n = notes.pop_front();
      chk({avs_response, avs_readdata & n[65:34]}, n[33:0]);
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({test_logic_in_reset, test_reset_n, synth_xdiv, 27'h0}, {1'b1, 1'b0, 5'h0, 27'h0});
    for (int i = 0; i < 11; i++) begin
      v = (i == 1 || i == 10) ? 32'h3 : 32'h0;
      bus(1'b0, i[5:0], 0, i == 2 ? 32'h4 : '1, i == 2 ? 32'h4 : v);
    end
    $display("test done: power-up values");
    while (!supply_good) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk({23'h0, synth_xdiv, synth_zdiv}, {23'h0, 5'h10, 6'h20});
    bus(1'b1, 6'h15, 0, 0, 0);
    bus(1'b1, 6'h16, 0, 0, 0);
    bus(1'b1, 6'h0B, rnd, 0, 0);
    for (int i = 12; i < 19; i++) bus(1'b1, i[5:0], 0, 0, 0);
    bus(1'b1, 6'h13, rnd, 0, 0);
    bus(1'b0, 6'h14, 0, 0, 0);
    bus(1'b0, 6'h17, 0, 32'h31F, 32'h11F);
    for (int i = 11; i < 20; i++) begin
      rnd = xs(rnd);
      if (i != 15) bus(1'b1, i[5:0], rnd, 0, 0);
      if (i != 15) bus(1'b0, i[5:0], 0, '1, rnd);
    end
    // low lanes only: upper half must keep the last random word
    avs_byteenable <= 4'h3;
    bus(1'b1, 6'h13, 32'hFFFF_FFFF, 0, 0);
    avs_byteenable <= 4'hF;
    bus(1'b0, 6'h13, 0, '1, {rnd[31:16], 16'hFFFF});
    bus(1'b1, 6'h3F, '1, 0, 0);
    bus(1'b1, 6'h17, 0, 0, 0);
    bus(1'b0, 6'h18, 0, '1, 0);
    bus(1'b0, 6'h3F, 0, '1, 0);
    rel_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b0, 6'h17, 0, 32'h31F, 32'h10F);
    bus(1'b1, 6'h01, 0, 0, 0);
    #1 chk({32'h0, icache_set_enable}, 34'h0);
    $display("test done: bring-up and refusals");
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b0, 6'h01, 0, '1, 32'h3);
    $display("test done: second reset");
    repeat (2) @(posedge core_clk);
    tally_and_finish();
  end
endmodule
